//--- logic/rsw_pkg.sv
package rsw_pkg;
  localparam int RSW_FRAME_BITS = 8;
  localparam logic [2:0] RSW_ADDR_MAP01 = 3'h0;
  localparam logic [2:0] RSW_ADDR_MAP23 = 3'h1;
  localparam logic [2:0] RSW_ADDR_MAP45 = 3'h2;
  localparam logic [2:0] RSW_ADDR_MAP67 = 3'h3;
  localparam logic [2:0] RSW_ADDR_FAULT_REPORT_BANK_CURRENT_ENABLE_LO = 3'h4;
  localparam logic [2:0] RSW_ADDR_FAULT_REPORT_BANK_CURRENT_ENABLE_HI = 3'h5;
  localparam logic [2:0] RSW_ADDR_ACTION = 3'h6;
  localparam logic [2:0] RSW_ADDR_SPARE = 3'h7;
  localparam logic [3:0] RSW_REG_RESET = 4'h0;
  localparam int RSW_FRM_WRITE_BIT = 7;
  localparam int RSW_FRM_ADDR_HI = 6;
  localparam int RSW_FRM_ADDR_LO = 4;
  localparam int RSW_FRM_STDDIAG_BIT = 1;
  localparam int RSW_FRM_BANK_BIT = 0;
  localparam int RSW_CMD_WAKE_BIT = 3;
  localparam int RSW_CMD_STANDBY_BIT = 2;
  localparam int RSW_CMD_RESET_BIT = 1;
  localparam int RSW_CMD_CLEARED_BIT = 0;
  localparam int RSW_STD_AWAKE_BIT = 5;
  localparam int RSW_STD_LIMP_BIT = 4;
  localparam logic [1:0] RSW_ANS_STD = 2'h0;
  localparam logic [1:0] RSW_ANS_FAULT_REPORT_BANK = 2'h1;
  localparam logic [1:0] RSW_ANS_CTRL = 2'h2;
  typedef enum logic [1:0] {RSW_LINK_IDLE, RSW_LINK_FRAME} rsw_link_state_t;
endpackage : rsw_pkg

//--- logic/rsw_frame_if.sv
`timescale 1ns/10ps
interface rsw_frame_if;
  logic frame_done;
  logic frame_ok;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic frame_start;
  modport link (output frame_done, output frame_ok, output rx_byte, output frame_start, input tx_byte);
  modport core (input frame_done, input frame_ok, input rx_byte, input frame_start, output tx_byte);
endinterface : rsw_frame_if

//--- logic/rsw_link.sv
`timescale 1ns/10ps
module rsw_link
  import rsw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic sclk_i,
  input wire logic sel_b_i,
  input wire logic sdi_i,
  input wire logic ter_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  rsw_frame_if.link frm
);
  logic [1:0] sclk_s_q, sel_s_q, sdi_s_q;
  logic sclk_d1_q, sel_d1_q;
  logic [7:0] shift_q;
  logic [2:0] cnt_q;
  logic any_q;
  rsw_link_state_t st_q;
  wire sclk_rise = sclk_s_q[1] & ~sclk_d1_q;
  wire sclk_fall = ~sclk_s_q[1] & sclk_d1_q;
  wire sel_fall = ~sel_s_q[1] & sel_d1_q;
  wire sel_rise = sel_s_q[1] & ~sel_d1_q;
  // pins are asynchronous; only the second stage is looked at
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_s_q <= 2'h0;
      sel_s_q <= 2'h3;
      sdi_s_q <= 2'h0;
      sclk_d1_q <= 1'b0;
      sel_d1_q <= 1'b1;
    end else begin
      sclk_s_q <= {sclk_s_q[0], sclk_i};
      sel_s_q <= {sel_s_q[0], sel_b_i};
      sdi_s_q <= {sdi_s_q[0], sdi_i};
      sclk_d1_q <= sclk_s_q[1];
      sel_d1_q <= sel_s_q[1];
    end
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= RSW_LINK_IDLE;
      shift_q <= 8'h00;
      cnt_q <= 3'h0;
      any_q <= 1'b0;
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
      frm.frame_done <= 1'b0;
      frm.frame_ok <= 1'b0;
      frm.rx_byte <= 8'h00;
      frm.frame_start <= 1'b0;
    end else begin
      frm.frame_done <= 1'b0;
      frm.frame_start <= 1'b0;
      case (st_q)
        RSW_LINK_IDLE: begin
          if (sel_fall) begin
            st_q <= RSW_LINK_FRAME;
            shift_q <= frm.tx_byte;
            cnt_q <= 3'h0;
            any_q <= 1'b0;
            sdo_oe_o <= 1'b1;
            sdo_o <= ter_i | sdi_s_q[1];
            frm.frame_start <= 1'b1;
          end
        end
        RSW_LINK_FRAME: begin
          if (sel_rise) begin
            st_q <= RSW_LINK_IDLE;
            sdo_oe_o <= 1'b0;
            frm.frame_done <= 1'b1;
            frm.frame_ok <= any_q && (cnt_q == 3'h0);
            frm.rx_byte <= shift_q;
          end else begin
            if (sclk_rise) begin
              sdo_o <= shift_q[RSW_FRAME_BITS-1];
            end
            if (sclk_fall) begin
              shift_q <= {shift_q[RSW_FRAME_BITS-2:0], sdi_s_q[1]};
              cnt_q <= cnt_q + 3'h1;
              any_q <= 1'b1;
            end
          end
        end
        default: st_q <= RSW_LINK_IDLE;
      endcase
    end
  end
endmodule : rsw_link

//--- logic/rsw_regs.sv
// Behaviour
// - status bit5 awake, bit4 limp home
// - status bits3..0 pair alerts, bit0 ch0/1
// - addresses 0..3 hold two mapping fields
// - address 4 current enables ch0..3
// - address 5 current enables ch4..7
// - address 6 wake, standby, reset, cleared
// - address 7 unused, no bits
// - power-on, standby, reset zero control registers
// - command bits self clear
// - cleared bit held until next valid frame
// - diagnosis 0..3 open-load and fault flags
// - write frame stores data at address
// - read frame answers in next frame
// - decode only whole bytes, else error flag
`timescale 1ns/10ps
module rsw_regs
  import rsw_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic SCLK_I,
  input wire logic SEL_B_I,
  input wire logic SDI_I,
  input wire logic [7:0] OPEN_LOAD_I,
  input wire logic [7:0] FAULT_I,
  input wire logic LIMP_HOME_I,
  output logic SDO_O,
  output logic SDO_OE_O,
  output logic [15:0] INPUT_MAP_O,
  output logic [7:0] FAULT_REPORT_BANK_CURRENT_EN_O,
  output logic WAKE_REQ_O,
  output logic STANDBY_REQ_O,
  output logic RESET_REQ_O,
  output logic AWAKE_O
);
  rsw_frame_if frm ();
  logic [3:0] ctrl_q [0:5];
  logic [7:0] ol_s1_q, ol_s2_q, flt_s1_q, flt_s2_q;
  logic lh_s1_q, lh_s2_q;
  logic ter_q;
  logic cleared_q;
  logic awake_q;
  logic [1:0] ans_kind_q;
  logic [2:0] ans_addr_q;
  logic [7:0] tx_d;
  logic [3:0] rd_data;
  logic wr_ok, rd_ok, sys_clear;

  function automatic logic [3:0] fault_report_bank_pair(input logic [7:0] ol, input logic [7:0] flt, input logic [1:0] p);
    fault_report_bank_pair = {ol[{p, 1'b1}], flt[{p, 1'b1}], ol[{p, 1'b0}], flt[{p, 1'b0}]};
  endfunction : fault_report_bank_pair

  rsw_link u_link (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .sclk_i(SCLK_I),
    .sel_b_i(SEL_B_I),
    .sdi_i(SDI_I),
    .ter_i(ter_q),
    .sdo_o(SDO_O),
    .sdo_oe_o(SDO_OE_O),
    .frm(frm.link)
  );

  // fault inputs come from the power stage, outside this clock
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ol_s1_q <= 8'h00;
      ol_s2_q <= 8'h00;
      flt_s1_q <= 8'h00;
      flt_s2_q <= 8'h00;
      lh_s1_q <= 1'b0;
      lh_s2_q <= 1'b0;
    end else begin
      ol_s1_q <= OPEN_LOAD_I;
      ol_s2_q <= ol_s1_q;
      flt_s1_q <= FAULT_I;
      flt_s2_q <= flt_s1_q;
      lh_s1_q <= LIMP_HOME_I;
      lh_s2_q <= lh_s1_q;
    end
  end

  assign wr_ok = frm.frame_done & frm.frame_ok & frm.rx_byte[RSW_FRM_WRITE_BIT];
  assign rd_ok = frm.frame_done & frm.frame_ok & ~frm.rx_byte[RSW_FRM_WRITE_BIT];
  // standby and reset act at frame end, so they never outlive the frame
  assign sys_clear = wr_ok && (frm.rx_byte[RSW_FRM_ADDR_HI:RSW_FRM_ADDR_LO] == RSW_ADDR_ACTION) &&
    (frm.rx_byte[RSW_CMD_STANDBY_BIT] || frm.rx_byte[RSW_CMD_RESET_BIT]);

  // error flag: set by reset and by any bad frame
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ter_q <= 1'b1;
    end else if (frm.frame_done) begin
      ter_q <= ~frm.frame_ok;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < 6; i++) begin
        ctrl_q[i] <= RSW_REG_RESET;
      end
    end else if (sys_clear) begin
      for (int i = 0; i < 6; i++) begin
        ctrl_q[i] <= RSW_REG_RESET;
      end
    end else if (wr_ok && frm.rx_byte[RSW_FRM_ADDR_HI:RSW_FRM_ADDR_LO] < RSW_ADDR_ACTION) begin
      ctrl_q[frm.rx_byte[RSW_FRM_ADDR_HI:RSW_FRM_ADDR_LO]] <= frm.rx_byte[3:0];
    end
  end

  // command pulses last one cycle after the frame that carries them
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      WAKE_REQ_O <= 1'b0;
      STANDBY_REQ_O <= 1'b0;
      RESET_REQ_O <= 1'b0;
    end else begin
      WAKE_REQ_O <= wr_ok && frm.rx_byte[RSW_FRM_ADDR_HI:RSW_FRM_ADDR_LO] == RSW_ADDR_ACTION &&
        frm.rx_byte[RSW_CMD_WAKE_BIT];
      STANDBY_REQ_O <= wr_ok && frm.rx_byte[RSW_FRM_ADDR_HI:RSW_FRM_ADDR_LO] == RSW_ADDR_ACTION &&
        frm.rx_byte[RSW_CMD_STANDBY_BIT];
      RESET_REQ_O <= wr_ok && frm.rx_byte[RSW_FRM_ADDR_HI:RSW_FRM_ADDR_LO] == RSW_ADDR_ACTION &&
        frm.rx_byte[RSW_CMD_RESET_BIT];
    end
  end

  // cleared bit: a new write wins over the clear by the same valid frame
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cleared_q <= 1'b0;
    end else if (wr_ok && frm.rx_byte[RSW_FRM_ADDR_HI:RSW_FRM_ADDR_LO] == RSW_ADDR_ACTION &&
                 frm.rx_byte[RSW_CMD_CLEARED_BIT]) begin
      cleared_q <= 1'b1;
    end else if (frm.frame_done && frm.frame_ok) begin
      cleared_q <= 1'b0;
    end
  end

  // awake: set by wake, dropped by standby
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      awake_q <= 1'b0;
    end else if (STANDBY_REQ_O) begin
      awake_q <= 1'b0;
    end else if (WAKE_REQ_O) begin
      awake_q <= 1'b1;
    end
  end

  // choose what the next frame will shift out
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ans_kind_q <= RSW_ANS_STD;
      ans_addr_q <= 3'h0;
    end else if (frm.frame_start) begin
      ans_kind_q <= RSW_ANS_STD;
    end else if (rd_ok) begin
      if (frm.rx_byte[RSW_FRM_STDDIAG_BIT]) begin
        ans_kind_q <= RSW_ANS_STD;
      end else if (frm.rx_byte[RSW_FRM_BANK_BIT]) begin
        ans_kind_q <= RSW_ANS_FAULT_REPORT_BANK;
      end else begin
        ans_kind_q <= RSW_ANS_CTRL;
      end
      ans_addr_q <= frm.rx_byte[RSW_FRM_ADDR_HI:RSW_FRM_ADDR_LO];
    end
  end

  always_comb begin
    rd_data = 4'h0;
    if (ans_addr_q < RSW_ADDR_ACTION) begin
      rd_data = ctrl_q[ans_addr_q];
    end else if (ans_addr_q == RSW_ADDR_ACTION) begin
      rd_data = {3'h0, cleared_q};
    end else begin
      rd_data = 4'h0;
    end
  end

  always_comb begin
    case (ans_kind_q)
      RSW_ANS_FAULT_REPORT_BANK: tx_d = {2'h1, ans_addr_q[1:0], fault_report_bank_pair(ol_s2_q, flt_s2_q, ans_addr_q[1:0])};
      RSW_ANS_CTRL: tx_d = {1'b1, ans_addr_q, rd_data};
      default: begin
        tx_d = 8'h00;
        tx_d[RSW_STD_AWAKE_BIT] = awake_q;
        tx_d[RSW_STD_LIMP_BIT] = lh_s2_q;
        for (int p = 0; p < 4; p++) begin
          tx_d[p] = |fault_report_bank_pair(ol_s2_q, flt_s2_q, 2'(p));
        end
      end
    endcase
  end
  assign frm.tx_byte = tx_d;

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      INPUT_MAP_O <= 16'h0000;
      FAULT_REPORT_BANK_CURRENT_EN_O <= 8'h00;
      AWAKE_O <= 1'b0;
    end else begin
      INPUT_MAP_O <= {ctrl_q[3], ctrl_q[2], ctrl_q[1], ctrl_q[0]};
      FAULT_REPORT_BANK_CURRENT_EN_O <= {ctrl_q[5], ctrl_q[4]};
      AWAKE_O <= awake_q;
    end
  end

  chk_error_on_bad: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    frm.frame_done && !frm.frame_ok |=> ter_q) else $error("bad frame did not set error flag");
  chk_error_clears: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    frm.frame_done && frm.frame_ok |=> !ter_q) else $error("good frame left error flag");
  chk_standby_zero: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    sys_clear |=> ctrl_q[0] == RSW_REG_RESET && ctrl_q[5] == RSW_REG_RESET) else $error("standby kept control");
  chk_wake_pulse: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    WAKE_REQ_O |=> !WAKE_REQ_O) else $error("wake request not self clearing");
  chk_cleared_held: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    cleared_q && !frm.frame_done |=> cleared_q) else $error("cleared bit dropped early");
  chk_write_stores: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    wr_ok && frm.rx_byte[RSW_FRM_ADDR_HI:RSW_FRM_ADDR_LO] == RSW_ADDR_MAP01 |=>
    ctrl_q[0] == $past(frm.rx_byte[3:0])) else $error("write lost");
  chk_read_answer: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    rd_ok && !frm.rx_byte[RSW_FRM_STDDIAG_BIT] && frm.rx_byte[RSW_FRM_BANK_BIT] |=>
    ans_kind_q == RSW_ANS_FAULT_REPORT_BANK) else $error("read not queued");
  chk_std_awake: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    ans_kind_q == RSW_ANS_STD |-> tx_d[RSW_STD_AWAKE_BIT] == awake_q) else $error("awake bit wrong");
endmodule : rsw_regs

//--- sim/rsw_host_model.sv
`timescale 1ns/10ps
module rsw_host_model (
  output logic sclk_o,
  output logic sel_b_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  logic [8:0] rx;
  event done_ev;
  initial begin
    sclk_o = 1'b0;
    sel_b_o = 1'b1;
    sdi_o = 1'b0;
    rx = '0;
  end
  // the command byte is repeated, so the last whole byte is always the command
  task automatic xfer(input logic [7:0] cmd, input int nb);
    // data low at select fall, so the first answer bit is the error flag alone
    sdi_o = 1'b0;
    sel_b_o = 1'b0;
    #250;
    rx = {sdo_i, 8'h00};
    for (int i = 0; i < nb; i++) begin
      sdi_o = cmd[7 - (i % 8)];
      sclk_o = 1'b1;
      #80;
      if (i < 8) rx[7 - i] = sdo_i;
      sclk_o = 1'b0;
      #80;
    end
    #170;
    sel_b_o = 1'b1;
    // released line shows a changed level, not the last bit
    sdi_o = ~sdi_o;
    #250;
    ->done_ev;
  endtask : xfer
endmodule : rsw_host_model

//--- sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import rsw_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sclk, sel_b, sdi, sdo, oe, wake, stby, rst_req, awake;
  logic [7:0] ol = 8'h00;
  logic [7:0] flt = 8'h00;
  logic limp = 1'b1;
  logic [15:0] map;
  logic [7:0] fault_report_bank_current_enable;
  logic [3:0] regs [6];
  logic ter_m, awake_m;
  logic [7:0] rd_q;
  logic [8:0] exq [$];
  int error_cnt = 0;
  int comparisons = 0;
  int n_wake = 0, n_stby = 0, n_rst = 0, e_wake = 0, e_stby = 0, e_rst = 0;

  always #2.5 clk = ~clk;

  rsw_regs u_rsw_regs (.CLK_I(clk), .RST_B_I(rst_b), .SCLK_I(sclk), .SEL_B_I(sel_b), .SDI_I(sdi),
    .OPEN_LOAD_I(ol), .FAULT_I(flt), .LIMP_HOME_I(limp), .SDO_O(sdo), .SDO_OE_O(oe),
    .INPUT_MAP_O(map), .FAULT_REPORT_BANK_CURRENT_EN_O(fault_report_bank_current_enable), .WAKE_REQ_O(wake), .STANDBY_REQ_O(stby),
    .RESET_REQ_O(rst_req), .AWAKE_O(awake));
  rsw_host_model u_rsw_host_model (.sclk_o(sclk), .sel_b_o(sel_b), .sdi_o(sdi), .sdo_i(sdo));

  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t exp %h got %h", $time, e, g);
    end
  endtask : chk

  task automatic close_out;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  // answer byte the device loads at select fall, given the previous command
  function automatic logic [7:0] ans_of(input logic [7:0] c);
    logic [1:0] a;
    a = c[5:4];
    // a pair alerts on an open load as well as on a fault
    if (c[7] | c[1]) return {2'b00, awake_m, limp, |(flt[7:6] | ol[7:6]), |(flt[5:4] | ol[5:4]),
      |(flt[3:2] | ol[3:2]), |(flt[1:0] | ol[1:0])};
    if (c[0]) return {2'b01, a, ol[2*a+1], flt[2*a+1], ol[2*a], flt[2*a]};
    if (c[6:4] < 3'h6) return {1'b1, c[6:4], regs[c[6:4]]};
    // cleared bit is always gone by the time its read answer is loaded
    return {1'b1, c[6:4], 4'h0};
  endfunction : ans_of

  task automatic frm(input logic [7:0] c, input int nb = 8);
    // a short frame never samples its low answer bits; they stay zero in the model
    exq.push_back({ter_m, ans_of(rd_q) & ~(8'hFF >> nb)});
    u_rsw_host_model.xfer(c, nb);
    rd_q = 8'h02;
    ter_m = (nb == 0 || nb % 8 != 0);
    if (!ter_m) begin
      if (!c[7] && !c[1]) rd_q = c;
      if (c[7] && c[6:4] < 3'h6) regs[c[6:4]] = c[3:0];
      if (c[7] && c[6:4] == 3'h6) begin
        if (c[3]) begin awake_m = 1'b1; e_wake++; end
        if (c[2]) begin awake_m = 1'b0; e_stby++; end
        if (c[2] | c[1]) regs = '{default: 4'h0};
        if (c[1]) e_rst++;
      end
    end
    chk({regs[3], regs[2], regs[1], regs[0]}, map);
    chk({8'h00, regs[5], regs[4]}, {8'h00, fault_report_bank_current_enable});
    chk({14'h0, awake_m, 1'b0}, {14'h0, awake, oe});
  endtask : frm

  always @(u_rsw_host_model.done_ev) begin
    if (exq.size() == 0) chk(16'h01FF, 16'h0000);
    else chk(16'(exq.pop_front()), 16'(u_rsw_host_model.rx));
  end

  always @(posedge clk) begin
    if (wake === 1'b1) n_wake++;
    if (stby === 1'b1) n_stby++;
    if (rst_req === 1'b1) n_rst++;
  end

  initial begin
    #200000;
    error_cnt++;
    close_out();
  end

  initial begin
    void'($urandom(32'h277e1418));
    regs = '{default: 4'h0};
    ter_m = 1'b1;
    awake_m = 1'b0;
    rd_q = 8'h02;
    flt = 8'($urandom);
    repeat (6) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    repeat (4) @(negedge clk);
    frm(8'h02);
    for (int a = 0; a < 8; a++) if (a != 6) frm({1'b1, 3'(a), 4'($urandom)});
    for (int a = 0; a < 9; a++) frm({1'b0, 3'(a), 4'h0});
    for (int a = 0; a < 4; a++) begin
      frm({2'b00, 2'(a), 4'h1});
      @(negedge clk);
      ol = 8'($urandom);
      flt = 8'($urandom);
    end
    frm(8'h02);
    @(negedge clk);
    ol = 8'h00;
    limp = 1'b0;
    frm(8'hF5, 7);
    frm(8'h9A, 0);
    frm(8'h02, 12);
    frm(8'h9A, 16);
    frm(8'h10);
    frm(8'hE8);
    frm(8'h02);
    frm(8'hE2);
    frm(8'hE1);
    frm(8'h60);
    frm(8'hC7);
    frm(8'hE4);
    frm(8'h02);
    repeat (20) @(posedge clk);
    chk(16'(e_wake * 256 + e_stby * 16 + e_rst), 16'(n_wake * 256 + n_stby * 16 + n_rst));
    close_out();
  end
endmodule : tb_top
